// [rtl/mcsab_bridge.sv]
/*
  sfr access bridge to the metering core: direct latched sfrs and
  pointer based indirect access paced by a metering clock enable.
  assumes sfr bus and metering core logic share CLK_I.
*/
`timescale 1ns/1ps
`include "mcsab_regs.svh"
module mcsab_bridge #(
  parameter int unsigned CLK_HZ  = `MCSAB_CLK_HZ,
  parameter int unsigned MCLK_HZ = `MCSAB_MCLK_HZ
) (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [7:0]  SFR_ADDR_I,
  input  wire logic        SFR_WR_I,
  input  wire logic        SFR_RD_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  output logic      [7:0]  SFR_RDATA_O,
  output logic             BUSY_O,
  input  wire logic [23:0] VRMS_I,
  input  wire logic [23:0] IRMS_I,
  input  wire logic [23:0] WAV1_I,
  input  wire logic [23:0] WAV2_I,
  input  wire logic [23:0] MIRQ_EN_I,
  input  wire logic [23:0] MIRQ_ST_I,
  output mcsab_pkg::mcsab_irqw_t MIRQ_WR_O,
  output logic             MCLK_EN_O,
  output logic      [5:0]  MREG_ADDR_O,
  output logic             MREG_WR_O,
  output logic             MREG_RD_O,
  output logic      [23:0] MREG_WDATA_O,
  input  wire logic [23:0] MREG_RDATA_I,
  input  wire logic [1:0]  MREG_LEN_I
);
  localparam int unsigned PW = `MCSAB_PHASE_W;
  localparam logic [PW-1:0] STEP =
    PW'((64'(MCLK_HZ) << PW) / 64'(CLK_HZ));
  if (MCLK_HZ == 0 || 2 * MCLK_HZ > CLK_HZ) begin : g_chk
    $error("metering rate must be below half the clock");
  end

  // ========================================================
  // decode
  function automatic logic [2:0] byte_of(input logic [7:0] a,
                                         input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    byte_of = {(a >= base) && (d < 8'h03), d[1:0]};
  endfunction

  // ========================================================
  // state
  mcsab_pkg::mcsab_ptr_t ptr_ff, nxt_ptr;
  logic [23:0]           mdat_ff, nxt_mdat;
  logic [23:0]           wdat_ff, nxt_wdat;
  logic [23:0]           shadow_ff [4];
  logic [23:0]           nxt_shadow [4];
  logic [23:0]           live [4];
  logic [7:0]            rdata_ff, nxt_rdata;
  logic                  req_ff, nxt_req;
  logic                  ack_ff, nxt_ack;
  logic                  settle_ff, nxt_settle;
  logic [PW-1:0]         phase_ff, nxt_phase;
  logic                  men_ff, nxt_men;
  mcsab_pkg::mcsab_irqw_t irqw_ff, nxt_irqw;
  mcsab_pkg::mcsab_ptr_t wr_ptr;
  logic                  pend;
  logic                  issue;
  logic [PW:0]           sum;
  logic [2:0]            hit;

  assign live[0] = VRMS_I;
  assign live[1] = IRMS_I;
  assign live[2] = WAV1_I;
  assign live[3] = WAV2_I;

  assign wr_ptr      = mcsab_pkg::mcsab_ptr_t'(SFR_WDATA_I);
  assign pend        = req_ff != ack_ff;
  assign issue       = men_ff && pend && settle_ff;
  assign MREG_WR_O   = issue && ptr_ff.dir;
  assign MREG_RD_O   = issue && !ptr_ff.dir;
  assign MREG_ADDR_O = ptr_ff.addr;
  assign MREG_WDATA_O = wdat_ff;
  assign SFR_RDATA_O = rdata_ff;
  assign BUSY_O      = pend;
  assign MCLK_EN_O   = men_ff;
  assign MIRQ_WR_O   = irqw_ff;

  // ========================================================
  // next state
  always_comb begin
    nxt_ptr    = ptr_ff;
    nxt_mdat   = mdat_ff;
    nxt_shadow = shadow_ff;
    nxt_rdata  = rdata_ff;
    nxt_req    = req_ff;
    nxt_ack    = ack_ff;
    nxt_settle = pend;
    nxt_irqw   = '0;
    hit        = 3'h0;
    // metering enable from a phase accumulator
    sum       = {1'b0, phase_ff} + {1'b0, STEP};
    nxt_phase = sum[PW-1:0];
    nxt_men   = sum[PW];
    // one-byte registers take only the low data byte
    nxt_wdat = (MREG_LEN_I == `MCSAB_LEN_ONE) ?
               {16'h0000, mdat_ff[7:0]} : mdat_ff;
    // reads
    if (SFR_RD_I) begin
      nxt_rdata = 8'h00;
      case (SFR_ADDR_I)
        `MCSAB_PTR_ADDR:  nxt_rdata = nxt_ptr;
        `MCSAB_DATL_ADDR: nxt_rdata = mdat_ff[7:0];
        `MCSAB_DATM_ADDR: nxt_rdata = mdat_ff[15:8];
        `MCSAB_DATH_ADDR: nxt_rdata = mdat_ff[23:16];
        default: begin
          for (int g = 0; g < 4; g++) begin
            case (g)
              0:       hit = byte_of(SFR_ADDR_I, `MCSAB_VRMS_BASE);
              1:       hit = byte_of(SFR_ADDR_I, `MCSAB_IRMS_BASE);
              2:       hit = byte_of(SFR_ADDR_I, `MCSAB_WAV1_BASE);
              default: hit = byte_of(SFR_ADDR_I, `MCSAB_WAV2_BASE);
            endcase
            if (hit[2]) begin
              if (hit[1:0] == `MCSAB_HIGH_IDX) begin
                nxt_shadow[g] = live[g];
                nxt_rdata     = live[g][23:16];
              end else begin
                nxt_rdata = shadow_ff[g][8*hit[1:0] +: 8];
              end
            end
          end
          hit = byte_of(SFR_ADDR_I, `MCSAB_IRQEN_BASE);
          if (hit[2]) begin
            nxt_rdata = MIRQ_EN_I[8*hit[1:0] +: 8];
          end
          hit = byte_of(SFR_ADDR_I, `MCSAB_IRQST_BASE);
          if (hit[2]) begin
            nxt_rdata = MIRQ_ST_I[8*hit[1:0] +: 8];
          end
        end
      endcase
    end
    // writes; indirect sfrs are refused while a transfer is pending
    if (SFR_WR_I) begin
      case (SFR_ADDR_I)
        `MCSAB_PTR_ADDR: begin
          if (!pend) begin
            nxt_ptr = wr_ptr;
            nxt_req = !req_ff;
          end
        end
        `MCSAB_DATL_ADDR: if (!pend) nxt_mdat[7:0]   = SFR_WDATA_I;
        `MCSAB_DATM_ADDR: if (!pend) nxt_mdat[15:8]  = SFR_WDATA_I;
        `MCSAB_DATH_ADDR: if (!pend) nxt_mdat[23:16] = SFR_WDATA_I;
        default: begin
          hit = byte_of(SFR_ADDR_I, `MCSAB_IRQEN_BASE);
          if (hit[2]) begin
            nxt_irqw = {1'b1, 1'b0, hit[1:0], SFR_WDATA_I};
          end
          hit = byte_of(SFR_ADDR_I, `MCSAB_IRQST_BASE);
          if (hit[2]) begin
            nxt_irqw = {1'b1, `MCSAB_IRQST_SEL + {1'b0, hit[1:0]},
                        SFR_WDATA_I};
          end
        end
      endcase
    end
    // metering side completes the transfer
    if (issue) begin
      nxt_ack    = req_ff;
      nxt_settle = 1'b0;
      if (!ptr_ff.dir) begin
        nxt_mdat = (MREG_LEN_I == `MCSAB_LEN_ONE) ?
                   {16'h0000, MREG_RDATA_I[7:0]} : MREG_RDATA_I;
      end
    end
  end

  // ========================================================
  // registers
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ptr_ff    <= `MCSAB_PTR_RESET;
      mdat_ff   <= `MCSAB_DAT_RESET;
      wdat_ff   <= `MCSAB_DAT_RESET;
      shadow_ff <= '{default: `MCSAB_DAT_RESET};
      rdata_ff  <= 8'h00;
      req_ff    <= 1'b0;
      ack_ff    <= 1'b0;
      settle_ff <= 1'b0;
      phase_ff  <= '0;
      men_ff    <= 1'b0;
      irqw_ff   <= '0;
    end else begin
      ptr_ff    <= nxt_ptr;
      mdat_ff   <= nxt_mdat;
      wdat_ff   <= nxt_wdat;
      shadow_ff <= nxt_shadow;
      rdata_ff  <= nxt_rdata;
      req_ff    <= nxt_req;
      ack_ff    <= nxt_ack;
      settle_ff <= nxt_settle;
      phase_ff  <= nxt_phase;
      men_ff    <= nxt_men;
      irqw_ff   <= nxt_irqw;
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_ptr_go;
    SFR_WR_I && SFR_ADDR_I == `MCSAB_PTR_ADDR && !pend;
  endsequence
  sequence s_rd(logic [7:0] a);
    SFR_RD_I && !SFR_WR_I && SFR_ADDR_I == a;
  endsequence

  AST_PTR_START: assert property (s_ptr_go |=> pend)
    else $error("pointer write did not start a transfer");
  AST_ADDR_FIELD: assert property (s_ptr_go |=>
      MREG_ADDR_O == $past(SFR_WDATA_I[6:1]))
    else $error("internal address not taken from bits 6:1");
  AST_WR_DIR: assert property (s_ptr_go && wr_ptr.dir |-> ##[2:300]
      (MREG_WR_O && !MREG_RD_O))
    else $error("write direction not honoured");
  AST_ONE_BYTE_WR: assert property (MREG_WR_O &&
      MREG_LEN_I == `MCSAB_LEN_ONE |-> MREG_WDATA_O[23:8] == 16'h0000)
    else $error("upper data bytes leaked on one-byte write");
  AST_ONE_BYTE_RD: assert property (MREG_RD_O &&
      MREG_LEN_I == `MCSAB_LEN_ONE |=> mdat_ff[23:8] == 16'h0000 &&
      mdat_ff[7:0] == $past(MREG_RDATA_I[7:0]))
    else $error("one-byte read did not clear upper bytes");
  AST_RD_LOAD: assert property (MREG_RD_O &&
      MREG_LEN_I != `MCSAB_LEN_ONE |=> mdat_ff == $past(MREG_RDATA_I))
    else $error("read data not loaded");
  AST_RATE: assert property ((MREG_WR_O || MREG_RD_O) |->
      men_ff ##1 !men_ff)
    else $error("transfer off the metering enable");
  AST_HOLD: assert property (pend && !issue |=> $stable(mdat_ff))
    else $error("data bytes changed during transfer");
  AST_DONE: assert property (s_ptr_go |-> ##[2:300] !pend)
    else $error("transfer not completed in time");
  AST_HIGH_LATCH: assert property (s_rd(`MCSAB_VRMS_BASE + 8'h02) |=>
      shadow_ff[0] == $past(VRMS_I))
    else $error("high byte read did not latch the sample");
  AST_LOW_OLD: assert property (s_rd(`MCSAB_WAV1_BASE) |=>
      SFR_RDATA_O == $past(shadow_ff[2][7:0]))
    else $error("low byte not from latched sample");
  AST_IRQ_RD: assert property (s_rd(`MCSAB_IRQST_BASE + 8'h01) |=>
      SFR_RDATA_O == $past(MIRQ_ST_I[15:8]))
    else $error("irq byte not latched at read");
endmodule

// [rtl/mcsab_regs.svh]
/*
  sfr addresses, pointer fields and timing constants of the metering bridge.
  assumes an sfr bus clocked by the same clock as the bridge.
*/
`ifndef MCSAB_REGS_SVH
`define MCSAB_REGS_SVH
// ==========================================================
// sfr map
`define MCSAB_PTR_ADDR    8'h91
`define MCSAB_DATL_ADDR   8'h92
`define MCSAB_DATM_ADDR   8'h93
`define MCSAB_DATH_ADDR   8'h94
`define MCSAB_VRMS_BASE   8'hd1
`define MCSAB_IRMS_BASE   8'hd4
`define MCSAB_IRQEN_BASE  8'hd9
`define MCSAB_IRQST_BASE  8'hdc
`define MCSAB_WAV1_BASE   8'he2
`define MCSAB_WAV2_BASE   8'he5
// ==========================================================
// fields and values
`define MCSAB_LEN_ONE     2'h1
`define MCSAB_HIGH_IDX    2'h2
`define MCSAB_IRQST_SEL   3'h3
`define MCSAB_PTR_RESET   8'h00
`define MCSAB_DAT_RESET   24'h000000
// ==========================================================
// timing
`define MCSAB_CLK_HZ      50000000
`define MCSAB_MCLK_HZ     819200
`define MCSAB_PHASE_W     24
`endif

// [rtl/mcsab_pkg.sv]
/*
  types of the metering bridge.
  assumes mcsab_regs.svh supplies the numbers.
*/
package mcsab_pkg;
  // ========================================================
  // pointer layout
  typedef struct packed {
    logic       dir;
    logic [5:0] addr;
    logic       spare;
  } mcsab_ptr_t;
  // ========================================================
  // three-byte direct groups
  typedef enum logic [1:0] {
    GRP_VRMS,
    GRP_IRMS,
    GRP_WAV1,
    GRP_WAV2
  } mcsab_grp_t;
  // ========================================================
  // irq byte write strobe
  typedef struct packed {
    logic       wr;
    logic [2:0] sel;
    logic [7:0] data;
  } mcsab_irqw_t;
endpackage

// [tb/mcsab_core_model.sv]
/*
  metering core model: indirect register file behind the bridge.
  assumes strobes come on the bridge clock with the metering enable.
*/
`timescale 1ns/1ps
module mcsab_core_model (
  input  wire logic        clk_i,
  input  wire logic        mclk_en_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [23:0] wdata_i,
  output logic      [23:0] rdata_o,
  output logic      [1:0]  len_o
);
  // ======
  // register file, short registers keep junk in their upper bytes
  logic [23:0] mem [64];
  initial for (int i = 0; i < 64; i++) mem[i] = {8'ha5 ^ 8'(i), 8'h5a, 8'(i)};
  assign len_o = (addr_i[5:4] == 2'h0) ? 2'h3 :
                 (addr_i[5:4] == 2'h1) ? 2'h1 : 2'h2;
  // ======
  // read data is only good during the strobe
  always_comb begin
    rdata_o = mem[addr_i];
    if (len_o == 2'h2) rdata_o[23:16] = 8'h00;
    if (rd_i !== 1'b1) rdata_o = ~rdata_o;
  end
  always @(posedge clk_i) begin
    if (wr_i === 1'b1 && mclk_en_i === 1'b1) begin
      if (len_o == 2'h1) mem[addr_i][7:0] <= wdata_i[7:0];
      else mem[addr_i] <= wdata_i;
    end
  end
endmodule

// [tb/tb_mcsab_bridge.sv]
/*
  bench of the metering bridge: sfr driver with queued expectations.
  assumes the core model answers the indirect strobes.
*/
`timescale 1ns/1ps
`include "mcsab_regs.svh"
module tb_mcsab_bridge;
  // ======
  // signals
  logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, pend = 1'b0;
  logic        busy, men, mwr, mrd;
  logic [7:0]  addr = 8'h00, wdat = 8'h00, rdat;
  logic [5:0]  madr;
  logic [1:0]  mlen;
  logic [23:0] mwd, mrdat, live [6];
  logic [7:0]  q_rd [$];
  logic [29:0] q_wr [$];
  logic [11:0] q_irq [$];
  mcsab_pkg::mcsab_irqw_t irqw;
  integer      num_errors = 0, n_tests = 0, seed = 32'hedc062d3;
  integer      gap = 0;
  logic        seen = 1'b0;
  mcsab_bridge dut_u (.CLK_I(clk), .NRST_I(nrst), .SFR_ADDR_I(addr),
    .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdat), .SFR_RDATA_O(rdat),
    .BUSY_O(busy), .VRMS_I(live[0]), .IRMS_I(live[1]), .WAV1_I(live[2]),
    .WAV2_I(live[3]), .MIRQ_EN_I(live[4]), .MIRQ_ST_I(live[5]),
    .MIRQ_WR_O(irqw), .MCLK_EN_O(men), .MREG_ADDR_O(madr),
    .MREG_WR_O(mwr), .MREG_RD_O(mrd), .MREG_WDATA_O(mwd),
    .MREG_RDATA_I(mrdat), .MREG_LEN_I(mlen));
  mcsab_core_model core_u (.clk_i(clk), .mclk_en_i(men), .addr_i(madr),
    .wr_i(mwr), .rd_i(mrd), .wdata_i(mwd), .rdata_o(mrdat), .len_o(mlen));
  initial forever #10 clk = ~clk;
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
  // ======
  // compares and verdict
  task automatic tally(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    tally(32'(e), 32'(g));
  endtask
  task automatic chk_mw(input logic [29:0] e, input logic [29:0] g);
    tally(32'(e), 32'(g));
  endtask
  task automatic chk_irq(input logic [11:0] e, input logic [11:0] g);
    tally(32'(e), 32'(g));
  endtask
  task automatic chk_gap(input integer g);
    integer lo;
    lo = `MCSAB_CLK_HZ / `MCSAB_MCLK_HZ;
    tally(32'h1, 32'(g >= lo && g <= lo + 1));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever begin
    @(negedge clk);
    if (pend) chk_rd(q_rd.size() > 0 ? q_rd.pop_front() : 8'hxx, rdat);
    pend = (rd === 1'b1);
    if (mwr === 1'b1)
      chk_mw(q_wr.size() > 0 ? q_wr.pop_front() : 'x, {madr, mwd});
    if (irqw.wr === 1'b1)
      chk_irq(q_irq.size() > 0 ? q_irq.pop_front() : 'x, irqw);
    gap++;
    if (men === 1'b1) begin
      if (seen) chk_gap(gap);
      seen = 1'b1;
      gap = 0;
    end
  end
  // ======
  // sfr bus cycles
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    wr = w;
    rd = !w;
    addr = a;
    wdat = d;
    if (!w) q_rd.push_back(e);
    @(posedge clk);
    #1;
  endtask
  task automatic idle();
    wr = 1'b0;
    rd = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    idle();
    while (busy !== 1'b0 && k < 200) begin
      idle();
      k++;
    end
    tally(32'h0, 32'(busy));
  endtask
  function automatic logic [23:0] fit(input logic [5:0] a,
                                      input logic [23:0] d);
    case (a[5:4])
      2'h0: fit = d;
      2'h1: fit = {16'h0000, d[7:0]};
      default: fit = {8'h00, d[15:0]};
    endcase
  endfunction
  task automatic mput(input logic [5:0] a, input logic [23:0] d);
    sfr(1'b1, `MCSAB_DATL_ADDR, d[7:0], 8'h00);
    sfr(1'b1, `MCSAB_DATM_ADDR, d[15:8], 8'h00);
    sfr(1'b1, `MCSAB_DATH_ADDR, d[23:16], 8'h00);
    q_wr.push_back({a, (a[5:4] == 2'h1) ? {16'h0000, d[7:0]} : d});
    sfr(1'b1, `MCSAB_PTR_ADDR, {1'b1, a, 1'b0}, 8'h00);
    wait_idle();
  endtask
  task automatic mget(input logic [5:0] a, input logic [23:0] e);
    sfr(1'b1, `MCSAB_PTR_ADDR, {1'b0, a, 1'b1}, 8'h00);
    wait_idle();
    sfr(1'b0, `MCSAB_PTR_ADDR, 8'h00, {1'b0, a, 1'b1});
    sfr(1'b0, `MCSAB_DATL_ADDR, 8'h00, e[7:0]);
    sfr(1'b0, `MCSAB_DATM_ADDR, 8'h00, e[15:8]);
    sfr(1'b0, `MCSAB_DATH_ADDR, 8'h00, e[23:16]);
  endtask
  // ======
  // scenarios
  initial begin
    logic [7:0]  bases [4];
    logic [23:0] v;
    bases = '{`MCSAB_VRMS_BASE, `MCSAB_IRMS_BASE,
              `MCSAB_WAV1_BASE, `MCSAB_WAV2_BASE};
    for (int i = 0; i < 6; i++) live[i] = 24'($random(seed));
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (int i = 'h90; i < 'h95; i++) sfr(1'b0, 8'(i), 8'h00, 8'h00);
    sfr(1'b0, `MCSAB_VRMS_BASE, 8'h00, 8'h00);
    $display("test reset done");
    sfr(1'b1, `MCSAB_DATM_ADDR, 8'h01, 8'h00);
    sfr(1'b1, `MCSAB_DATL_ADDR, 8'h55, 8'h00);
    q_wr.push_back({6'h0a, 24'h000155});
    sfr(1'b1, `MCSAB_PTR_ADDR, 8'h94, 8'h00);
    if (busy === 1'b1) begin
      sfr(1'b1, `MCSAB_DATL_ADDR, 8'haa, 8'h00);
      sfr(1'b1, `MCSAB_PTR_ADDR, 8'h96, 8'h00);
    end
    wait_idle();
    sfr(1'b0, `MCSAB_PTR_ADDR, 8'h00, 8'h94);
    sfr(1'b0, `MCSAB_DATL_ADDR, 8'h00, 8'h55);
    mget(6'h0a, 24'h000155);
    $display("test walk done");
    for (int i = 0; i < 8; i++) begin
      v = 24'($random(seed));
      mput({2'(i), v[11:8]}, v);
      mget({2'(i), v[11:8]}, fit({2'(i), v[11:8]}, v));
    end
    $display("test indirect done");
    for (int g = 0; g < 4; g++) begin
      sfr(1'b0, bases[g] + 8'h2, 8'h00, live[g][23:16]);
      v = live[g];
      live[g] = 24'($random(seed));
      sfr(1'b1, bases[g], 8'hff, 8'h00);
      sfr(1'b0, bases[g] + 8'h1, 8'h00, v[15:8]);
      sfr(1'b0, bases[g], 8'h00, v[7:0]);
      sfr(1'b0, bases[g] + 8'h2, 8'h00, live[g][23:16]);
      sfr(1'b0, bases[g], 8'h00, live[g][7:0]);
    end
    $display("test direct done");
    for (int s = 0; s < 6; s++) begin
      v = live[4 + s / 3];
      sfr(1'b0, `MCSAB_IRQEN_BASE + 8'(s), 8'h00, v[8 * (s % 3) +: 8]);
      live[4 + s / 3] = 24'($random(seed));
      q_irq.push_back({1'b1, 3'(s), v[7:0]});
      sfr(1'b1, `MCSAB_IRQEN_BASE + 8'(s), v[7:0], 8'h00);
    end
    repeat (4) idle();
    $display("test irq done");
    final_report();
  end
endmodule
